// *** src/region_monitor_consts.vh ***
`ifndef REGION_MONITOR_CONSTS_VH
`define REGION_MONITOR_CONSTS_VH

// register offsets (word index = byte address / 4)
`define REG_THR_LL        8'h00
`define REG_THR_L         8'h04
`define REG_THR_H         8'h08
`define REG_THR_HH        8'h0C
`define REG_HYST          8'h10
`define REG_DISC_CUR      8'h14
`define REG_DISC_TIME     8'h18
`define REG_CFG           8'h1C
`define REG_REGIONS       8'h20
`define REG_FAULTS        8'h24
`define REG_IRQ_STAT      8'h28
`define REG_IRQ_MASK      8'h2C

// config register fields
`define CFG_MODE_LSB      0
`define CFG_WARN_SEL_BIT  2
`define CFG_FS_EXC_BIT    3
`define CFG_FS_MIS_BIT    4
`define CFG_FS_WARN_BIT   5

// channel modes
`define MODE_1OO1         2'h0
`define MODE_1OO2         2'h1
`define MODE_2OO3         2'h2

// region codes one-hot: ll, l, normal, h, hh
`define REGION_LL         5'h01
`define REGION_L          5'h02
`define REGION_N          5'h04
`define REGION_H          5'h08
`define REGION_HH         5'h10

// reset values, currents in microamps
`define RST_THR_LL        16'h0BB8
`define RST_THR_L         16'h0FA0
`define RST_THR_H         16'h4E20
`define RST_THR_HH        16'h5208
`define RST_HYST          16'h0064
`define RST_DISC_CUR      16'h01F4
`define RST_CFG           8'h00

// timing: discrepancy time in microseconds, clock in MHz
`define DISC_TIME_US      32'h000186A0
`define CLK_MHZ           32'h00000032

`endif

// *** src/channel_region_tracker.v ***
`timescale 1ns/10ps
`include "region_monitor_consts.vh"

// hysteretic five-region classifier for one channel
module channel_region_tracker
#(
  parameter W = 16
)
(
  // clock and reset
  input  wire         i_sys_clk,
  input  wire         i_reset,
  // sample and shared configuration
  input  wire [W-1:0] i_current,
  input  wire [W-1:0] i_thr_ll,
  input  wire [W-1:0] i_thr_l,
  input  wire [W-1:0] i_thr_h,
  input  wire [W-1:0] i_thr_hh,
  input  wire [W-1:0] i_hyst,
  // one-hot region
  output reg  [4:0]   o_region
);

  reg [2:0] lvl_nxt;
  reg [2:0] lvl_r;

  // level above threshold k needs cur >= thr+hyst, below needs cur <= thr-hyst
  function above;
    input [W-1:0] cur;
    input [W-1:0] thr;
    input [W-1:0] hy;
    begin
      above = ({1'b0, cur} >= ({1'b0, thr} + {1'b0, hy}));
    end
  endfunction

  function below;
    input [W-1:0] cur;
    input [W-1:0] thr;
    input [W-1:0] hy;
    begin
      below = ({1'b0, cur} + {1'b0, hy} <= {1'b0, thr});
    end
  endfunction

  // count of thresholds passed; inside a band the old level holds
  always @*
  begin
    lvl_nxt = 3'h0;
    if (!below(i_current, i_thr_ll, i_hyst) && (lvl_r >= 3'h1 ||
        above(i_current, i_thr_ll, i_hyst)))
      lvl_nxt = 3'h1;
    if (!below(i_current, i_thr_l, i_hyst) && (lvl_r >= 3'h2 ||
        above(i_current, i_thr_l, i_hyst)))
      lvl_nxt = 3'h2;
    if (!below(i_current, i_thr_h, i_hyst) && (lvl_r >= 3'h3 ||
        above(i_current, i_thr_h, i_hyst)))
      lvl_nxt = 3'h3;
    if (!below(i_current, i_thr_hh, i_hyst) && (lvl_r >= 3'h4 ||
        above(i_current, i_thr_hh, i_hyst)))
      lvl_nxt = 3'h4;
  end

  // one-hot output, normal region after reset
  always @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      lvl_r    <= 3'h2;
      o_region <= `REGION_N;
    end
    else
    begin
      lvl_r    <= lvl_nxt;
      o_region <= 5'h01 << lvl_nxt;
    end
  end

endmodule

// *** src/current_loop_region_monitor.v ***
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`include "region_monitor_consts.vh"

module current_loop_region_monitor
#(
  parameter W             = 16,
  parameter DISC_CYCLES   = `DISC_TIME_US * `CLK_MHZ
)
(
  // clock and reset
  input  wire         i_sys_clk,
  input  wire         i_reset,
  // measurement front end, currents in microamps
  input  wire [W-1:0] i_current_ch0,
  input  wire [W-1:0] i_current_ch1,
  input  wire [W-1:0] i_current_ch2,
  input  wire [2:0]   i_excess_current,
  // register port
  input  wire [7:0]   i_addr,
  input  wire [31:0]  i_wdata,
  input  wire         i_wr,
  input  wire         i_rd,
  output reg  [31:0]  o_rdata,
  // region flags to the user state machine
  output reg  [2:0]   o_low_low_region_flag,
  output reg  [2:0]   o_low_region_flag,
  output reg  [2:0]   o_normal_region_flag,
  output reg  [2:0]   o_analog_high_region_flag,
  output reg  [2:0]   o_analog_high_high_region_flag,
  // fault conditions usable as transitions
  output reg  [2:0]   o_excess_current_fault,
  output reg          o_channel_mismatch_fault,
  output reg          o_channel_mismatch_warning,
  // module fail-safe trigger and interrupt
  output reg          o_failsafe_trigger,
  output reg          o_irq
);

  // configuration registers
  reg [W-1:0]  thr_ll_r;
  reg [W-1:0]  thr_l_r;
  reg [W-1:0]  thr_h_r;
  reg [W-1:0]  thr_hh_r;
  reg [W-1:0]  hyst_r;
  reg [W-1:0]  disc_cur_r;
  reg [31:0]   disc_time_r;
  reg [7:0]    cfg_r;
  reg [5:0]    irq_mask_r;
  reg [5:0]    irq_stat_r;
  reg [5:0]    irq_stat_nxt;

  // synchronised front-end fault pins
  reg [2:0]    exc_meta_r;
  reg [2:0]    exc_sync_r;
  reg [2:0]    exc_latch_r;

  // discrepancy tracking
  reg [31:0]   disc_cnt_r;
  reg          mismatch_r;
  reg          fs_latch_r;

  wire [4:0]   region0;
  wire [4:0]   region1;
  wire [4:0]   region2;
  wire [1:0]   mode;
  wire [2:0]   ch_used;
  wire         mismatch_now;
  wire         disc_expired;
  wire         mis_evt;
  wire [2:0]   exc_evt;
  wire         fs_exc_any;
  wire         fs_now;
  wire [4:0]   region_changed;

  // absolute difference between two channels
  function [W-1:0] absdiff;
    input [W-1:0] a;
    input [W-1:0] b;
    begin
      absdiff = (a > b) ? (a - b) : (b - a);
    end
  endfunction

  // pair out of tolerance test
  function differ;
    input [W-1:0] a;
    input [W-1:0] b;
    input [W-1:0] lim;
    begin
      differ = (absdiff(a, b) > lim);
    end
  endfunction

  assign mode    = cfg_r[`CFG_MODE_LSB+1:`CFG_MODE_LSB];
  // channels belonging to the configuration
  assign ch_used = (mode == `MODE_1OO1) ? 3'b001 :
                   (mode == `MODE_1OO2) ? 3'b011 : 3'b111;

  // the same shared thresholds feed every channel tracker
  channel_region_tracker #(.W(W)) u_trk0
  (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_current (i_current_ch0),
    .i_thr_ll  (thr_ll_r),
    .i_thr_l   (thr_l_r),
    .i_thr_h   (thr_h_r),
    .i_thr_hh  (thr_hh_r),
    .i_hyst    (hyst_r),
    .o_region  (region0)
  );

  channel_region_tracker #(.W(W)) u_trk1
  (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_current (i_current_ch1),
    .i_thr_ll  (thr_ll_r),
    .i_thr_l   (thr_l_r),
    .i_thr_h   (thr_h_r),
    .i_thr_hh  (thr_hh_r),
    .i_hyst    (hyst_r),
    .o_region  (region1)
  );

  channel_region_tracker #(.W(W)) u_trk2
  (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_current (i_current_ch2),
    .i_thr_ll  (thr_ll_r),
    .i_thr_l   (thr_l_r),
    .i_thr_h   (thr_h_r),
    .i_thr_hh  (thr_hh_r),
    .i_hyst    (hyst_r),
    .o_region  (region2)
  );

  // any pair of used channels out of tolerance; single mode never compares
  assign mismatch_now =
    (mode == `MODE_1OO2) ? differ(i_current_ch0, i_current_ch1, disc_cur_r) :
    (mode == `MODE_2OO3) ? (differ(i_current_ch0, i_current_ch1, disc_cur_r) |
                            differ(i_current_ch0, i_current_ch2, disc_cur_r) |
                            differ(i_current_ch1, i_current_ch2, disc_cur_r)) :
    1'b0;

  // the difference must outlast the discrepancy time
  assign disc_expired = mismatch_now && (disc_cnt_r >= disc_time_r);
  assign mis_evt      = disc_expired && !mismatch_r;

  // pin faults only count on channels of the configuration
  assign exc_evt      = exc_sync_r & ch_used & ~exc_latch_r;

  // routing of each fault to fail-safe or to the state machine
  assign fs_exc_any = cfg_r[`CFG_FS_EXC_BIT] && (|(exc_latch_r & ch_used));
  assign fs_now = fs_exc_any ||
                  (mismatch_r && !cfg_r[`CFG_WARN_SEL_BIT] && cfg_r[`CFG_FS_MIS_BIT]) ||
                  (mismatch_r && cfg_r[`CFG_WARN_SEL_BIT] && cfg_r[`CFG_FS_WARN_BIT]);

  assign region_changed = {o_analog_high_high_region_flag[0] ^ region0[4],
                           o_analog_high_region_flag[0] ^ region0[3],
                           o_normal_region_flag[0] ^ region0[2],
                           o_low_region_flag[0] ^ region0[1],
                           o_low_low_region_flag[0] ^ region0[0]};

  // two-flop synchroniser for asynchronous front-end pins
  always @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      exc_meta_r <= 3'h0;
      exc_sync_r <= 3'h0;
    end
    else
    begin
      exc_meta_r <= i_excess_current;
      exc_sync_r <= exc_meta_r;
    end
  end

  // persistence counter; restarts whenever channels agree again
  always @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      disc_cnt_r <= 32'h0;
      mismatch_r <= 1'b0;
    end
    else
    begin
      if (!mismatch_now)
        disc_cnt_r <= 32'h0;
      else if (disc_cnt_r < disc_time_r)
        disc_cnt_r <= disc_cnt_r + 32'h1;
      mismatch_r <= disc_expired;
    end
  end

  // excess current latches until reset, like a powered-down channel
  always @(posedge i_sys_clk)
  begin
    if (i_reset)
      exc_latch_r <= 3'h0;
    else
      exc_latch_r <= exc_latch_r | (exc_sync_r & ch_used);
  end

  // fail-safe is sticky: only a reset leaves it, as with a supply cycle
  always @(posedge i_sys_clk)
  begin
    if (i_reset)
      fs_latch_r <= 1'b0;
    else if (fs_now)
      fs_latch_r <= 1'b1;
  end

  // status bits: set wins over the read clear
  always @*
  begin
    irq_stat_nxt = irq_stat_r;
    if (i_rd && i_addr == `REG_IRQ_STAT)
      irq_stat_nxt = 6'h0;
    irq_stat_nxt = irq_stat_nxt |
                   {fs_now && !fs_latch_r, mis_evt, (|region_changed), exc_evt};
  end

  // register writes
  always @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      thr_ll_r    <= `RST_THR_LL;
      thr_l_r     <= `RST_THR_L;
      thr_h_r     <= `RST_THR_H;
      thr_hh_r    <= `RST_THR_HH;
      hyst_r      <= `RST_HYST;
      disc_cur_r  <= `RST_DISC_CUR;
      disc_time_r <= DISC_CYCLES;
      cfg_r       <= `RST_CFG;
      irq_mask_r  <= 6'h0;
      irq_stat_r  <= 6'h0;
    end
    else
    begin
      irq_stat_r <= irq_stat_nxt;
      if (i_wr)
      begin
        case (i_addr)
          `REG_THR_LL:    thr_ll_r    <= i_wdata[W-1:0];
          `REG_THR_L:     thr_l_r     <= i_wdata[W-1:0];
          `REG_THR_H:     thr_h_r     <= i_wdata[W-1:0];
          `REG_THR_HH:    thr_hh_r    <= i_wdata[W-1:0];
          `REG_HYST:      hyst_r      <= i_wdata[W-1:0];
          `REG_DISC_CUR:  disc_cur_r  <= i_wdata[W-1:0];
          `REG_DISC_TIME: disc_time_r <= i_wdata;
          `REG_CFG:       cfg_r       <= i_wdata[7:0];
          `REG_IRQ_MASK:  irq_mask_r  <= i_wdata[5:0];
          default:        ;
        endcase
      end
    end
  end

  // read data one cycle after the strobe, zero otherwise or when unmapped
  always @(posedge i_sys_clk)
  begin
    if (i_reset)
      o_rdata <= 32'h0;
    else if (i_rd)
    begin
      case (i_addr)
        `REG_THR_LL:    o_rdata <= {{(32-W){1'b0}}, thr_ll_r};
        `REG_THR_L:     o_rdata <= {{(32-W){1'b0}}, thr_l_r};
        `REG_THR_H:     o_rdata <= {{(32-W){1'b0}}, thr_h_r};
        `REG_THR_HH:    o_rdata <= {{(32-W){1'b0}}, thr_hh_r};
        `REG_HYST:      o_rdata <= {{(32-W){1'b0}}, hyst_r};
        `REG_DISC_CUR:  o_rdata <= {{(32-W){1'b0}}, disc_cur_r};
        `REG_DISC_TIME: o_rdata <= disc_time_r;
        `REG_CFG:       o_rdata <= {24'h0, cfg_r};
        `REG_REGIONS:   o_rdata <= {17'h0, region2, region1, region0};
        `REG_FAULTS:    o_rdata <= {27'h0, fs_latch_r, mismatch_r, exc_latch_r};
        `REG_IRQ_STAT:  o_rdata <= {26'h0, irq_stat_r};
        `REG_IRQ_MASK:  o_rdata <= {26'h0, irq_mask_r};
        default:        o_rdata <= 32'h0;
      endcase
    end
    else
      o_rdata <= 32'h0;
  end

  // outputs to the state machine; all three channels' region flags come from their trackers, used or not
  always @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      o_low_low_region_flag          <= 3'h0;
      o_low_region_flag              <= 3'h0;
      o_normal_region_flag           <= 3'h7;
      o_analog_high_region_flag      <= 3'h0;
      o_analog_high_high_region_flag <= 3'h0;
      o_excess_current_fault         <= 3'h0;
      o_channel_mismatch_fault       <= 1'b0;
      o_channel_mismatch_warning     <= 1'b0;
      o_failsafe_trigger             <= 1'b0;
      o_irq                          <= 1'b0;
    end
    else
    begin
      o_low_low_region_flag          <= {region2[0], region1[0], region0[0]};
      o_low_region_flag              <= {region2[1], region1[1], region0[1]};
      o_normal_region_flag           <= {region2[2], region1[2], region0[2]};
      o_analog_high_region_flag      <= {region2[3], region1[3], region0[3]};
      o_analog_high_high_region_flag <= {region2[4], region1[4], region0[4]};
      // fail-safe routed faults are withheld from transitions
      o_excess_current_fault         <= cfg_r[`CFG_FS_EXC_BIT] ? 3'h0 : (exc_latch_r & ch_used);
      // fault or warning as configured
      o_channel_mismatch_fault       <= mismatch_r && !cfg_r[`CFG_WARN_SEL_BIT] &&
                                        !cfg_r[`CFG_FS_MIS_BIT];
      o_channel_mismatch_warning     <= mismatch_r && cfg_r[`CFG_WARN_SEL_BIT] &&
                                        !cfg_r[`CFG_FS_WARN_BIT];
      o_failsafe_trigger             <= fs_latch_r || fs_now;
      o_irq                          <= |(irq_stat_nxt & irq_mask_r);
    end
  end

endmodule

// *** tb/region_monitor_properties.sv ***
`timescale 1ns/10ps
`include "region_monitor_consts.vh"

// port-level relations that a slip in the monitor body would break
module region_monitor_properties
#(
  parameter W           = 16,
  parameter DISC_CYCLES = 5000000
)
(
  // clock and reset
  input wire         i_sys_clk,
  input wire         i_reset,
  // watched inputs
  input wire [W-1:0] i_current_ch0,
  input wire [W-1:0] i_current_ch1,
  input wire [W-1:0] i_current_ch2,
  input wire [2:0]   i_excess_current,
  input wire [7:0]   i_addr,
  input wire         i_wr,
  input wire         i_rd,
  // watched outputs
  input wire [31:0]  o_rdata,
  input wire [2:0]   o_low_low_region_flag,
  input wire [2:0]   o_low_region_flag,
  input wire [2:0]   o_normal_region_flag,
  input wire [2:0]   o_analog_high_region_flag,
  input wire [2:0]   o_analog_high_high_region_flag,
  input wire [2:0]   o_excess_current_fault,
  input wire         o_channel_mismatch_fault,
  input wire         o_channel_mismatch_warning,
  input wire         o_failsafe_trigger
);
  // per-channel region vectors, bit0 low-low up to bit4 high-high
  wire [4:0] ch0 = {o_analog_high_high_region_flag[0], o_analog_high_region_flag[0],
                    o_normal_region_flag[0], o_low_region_flag[0], o_low_low_region_flag[0]};
  wire [4:0] ch1 = {o_analog_high_high_region_flag[1], o_analog_high_region_flag[1],
                    o_normal_region_flag[1], o_low_region_flag[1], o_low_low_region_flag[1]};
  wire [4:0] ch2 = {o_analog_high_high_region_flag[2], o_analog_high_region_flag[2],
                    o_normal_region_flag[2], o_low_region_flag[2], o_low_low_region_flag[2]};
  wire       diff = (i_current_ch0 != i_current_ch1) || (i_current_ch1 != i_current_ch2) ||
                    (i_current_ch0 != i_current_ch2);

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  chk_region_one_hot: assert property ($onehot(ch0) && $onehot(ch1) && $onehot(ch2))
    else $error("region flags not one-hot");
  chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside its cycle");
  chk_rdata_regions: assert property (($past(i_rd) && $past(i_addr) == `REG_REGIONS)
    |-> o_rdata[14:0] == {ch2, ch1, ch0}) else $error("region word differs from flags");
  // quiet ch0 input and no configuration writes: no ch0 region change may appear
  chk_region_hold: assert property ((!i_wr && $stable(i_current_ch0)) [*4] |=> $stable(ch0))
    else $error("region moved with a steady input");
  chk_failsafe_sticky: assert property (o_failsafe_trigger |=> o_failsafe_trigger)
    else $error("fail-safe trigger dropped");
  chk_excess_cause: assert property ($rose(o_excess_current_fault[0])
    |-> ($past(i_excess_current[0], 3) || $past(i_excess_current[0], 4)))
    else $error("excess fault without its pin");
  chk_mismatch_kind: assert property (!(o_channel_mismatch_fault && o_channel_mismatch_warning))
    else $error("mismatch fault and warning together");
  chk_mismatch_wait: assert property (($rose(o_channel_mismatch_fault) ||
    $rose(o_channel_mismatch_warning)) |-> $past(diff, 2)) else $error("mismatch too early");
endmodule

bind current_loop_region_monitor region_monitor_properties #(.W(W), .DISC_CYCLES(DISC_CYCLES))
  chk_inst (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_current_ch0(i_current_ch0),
  .i_current_ch1(i_current_ch1), .i_current_ch2(i_current_ch2),
  .i_excess_current(i_excess_current), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_low_low_region_flag(o_low_low_region_flag),
  .o_low_region_flag(o_low_region_flag), .o_normal_region_flag(o_normal_region_flag),
  .o_analog_high_region_flag(o_analog_high_region_flag),
  .o_analog_high_high_region_flag(o_analog_high_high_region_flag),
  .o_excess_current_fault(o_excess_current_fault),
  .o_channel_mismatch_fault(o_channel_mismatch_fault),
  .o_channel_mismatch_warning(o_channel_mismatch_warning),
  .o_failsafe_trigger(o_failsafe_trigger));

// *** tb/user_sm_model.sv ***
`timescale 1ns/10ps

// user state machine: leaves its run state on a high reading or a fault
module user_sm_model
(
  // clock and reset
  input  wire       i_sys_clk,
  input  wire       i_reset,
  // flags from the monitor
  input  wire [2:0] i_high_flag,
  input  wire [2:0] i_high_high_flag,
  input  wire       i_mismatch_fault,
  input  wire [2:0] i_excess_fault,
  // trip state, sticky until reset
  output reg        o_trip_state
);
  // high-high counts as hidden, so it is ORed with high
  // mismatch fault and ch0 excess fault are transitions; the mismatch warning is not taken in
  always @(posedge i_sys_clk)
  begin
    if (i_reset)
      o_trip_state <= 1'b0;
    else if (i_high_flag[0] | i_high_high_flag[0] | i_mismatch_fault | i_excess_fault[0])
      o_trip_state <= 1'b1;
  end
endmodule

// *** tb/test_current_loop_region_monitor.sv ***
`timescale 1ns/10ps

module test_current_loop_region_monitor;
  reg         clk, rst, wr, rd;
  reg  [15:0] c0, c1, c2;
  reg  [2:0]  exc;
  reg  [7:0]  addr;
  reg  [31:0] wdata, d;
  wire [31:0] rdata;
  wire [2:0]  ll, lo, nm, hi, hh, exf;
  wire        mf, mw, fs, irq, trip;
  integer     err_count, total_checks, k;
  reg  [31:0] rv [0:7];
  reg  [15:0] sc [0:9];
  reg  [4:0]  se [0:9];

  current_loop_region_monitor current_loop_region_monitor_inst (.i_sys_clk(clk), .i_reset(rst),
    .i_current_ch0(c0), .i_current_ch1(c1), .i_current_ch2(c2), .i_excess_current(exc),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_low_low_region_flag(ll), .o_low_region_flag(lo), .o_normal_region_flag(nm),
    .o_analog_high_region_flag(hi), .o_analog_high_high_region_flag(hh),
    .o_excess_current_fault(exf), .o_channel_mismatch_fault(mf),
    .o_channel_mismatch_warning(mw), .o_failsafe_trigger(fs), .o_irq(irq));
  user_sm_model user_sm_model_inst (.i_sys_clk(clk), .i_reset(rst), .i_high_flag(hi),
    .i_high_high_flag(hh), .i_mismatch_fault(mf), .i_excess_fault(exf), .o_trip_state(trip));

  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task summarize;
  begin
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask

  task chk(input string n, input [31:0] seen, input [31:0] exp);
  begin
    total_checks = total_checks + 1;
    if (seen !== exp)
    begin
      err_count = err_count + 1;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  end
  endtask

  // waits n edges, then lets their updates land before sampling
  task cyc(input integer n);
  begin
    repeat (n) @(posedge clk);
    #1;
  end
  endtask

  task wreg(input [7:0] a, input [31:0] v);
  begin
    @(posedge clk);
    addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  end
  endtask

  // read data stand only in the cycle after the strobe
  task rreg(input [7:0] a);
  begin
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  end
  endtask

  task setc(input [15:0] a, input [15:0] b, input [15:0] c);
  begin
    @(posedge clk);
    c0 <= a; c1 <= b; c2 <= c;
  end
  endtask

  // hang guard, far beyond the few hundred cycles the sequence needs
  initial
  begin
    #400000;
    err_count = err_count + 1;
    summarize;
  end

  initial
  begin
    rv = '{32'h0BB8, 32'h0FA0, 32'h4E20, 32'h5208, 32'h64, 32'h1F4, 32'h4C4B40, 32'h0};
    sc = '{16'h4E83, 16'h4E84, 16'h4DBD, 16'h4DBC, 16'h526C,
           16'h0B54, 16'h0C1B, 16'h0C1C, 16'h1004, 16'h0F3D};
    se = '{5'h04, 5'h08, 5'h08, 5'h04, 5'h10, 5'h01, 5'h01, 5'h02, 5'h04, 5'h04};
    err_count = 0; total_checks = 0;
    rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0; exc = 3'h0;
    c0 = 16'h2710; c1 = 16'h2710; c2 = 16'h2710;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    cyc(3);
    chk("trip idle", trip, 0);
    for (k = 0; k < 8; k = k + 1)
    begin
      rreg(k * 4);
      chk("reset value", d, rv[k]);
    end
    wreg(8'h30, 32'hFFFF);
    rreg(8'h30);
    chk("unmapped", d, 0);
    // increasing thresholds, spacing over twice hysteresis, nonzero limit
    for (k = 0; k < 6; k = k + 1)
      wreg(k * 4, rv[k]);
    wreg(8'h18, 32'h5);
    wreg(8'h2C, 32'h3F);
    // sweep all channels up over every threshold at the band edges, and down over the high one
    for (k = 0; k < 10; k = k + 1)
    begin
      setc(sc[k], sc[k], sc[k]);
      cyc(3);
      chk("flags ch1", {hh[1], hi[1], nm[1], lo[1], ll[1]}, se[k]);
      rreg(8'h20);
      chk("regions", d, {17'h0, se[k], se[k], se[k]});
    end
    chk("trip high", trip, 1);
    // drop the sweep's region-change status so only the excess bit can raise irq
    rreg(8'h28);
    chk("irq cleared", irq, 0);
    @(posedge clk);
    exc <= 3'h3;
    cyc(6);
    chk("excess used only", exf, 1);
    chk("no fail-safe", fs, 0);
    @(posedge clk);
    exc <= 3'h0;
    cyc(3);
    chk("excess latched", exf, 1);
    chk("irq", irq, 1);
    rreg(8'h28);
    chk("excess status", d[0], 1);
    // dual mode, ch1 off by more than the limit
    wreg(8'h1C, 32'h1);
    rreg(8'h28);
    setc(16'h0F3D, 16'h1195, 16'h0F3D);
    cyc(5);
    chk("mismatch early", mf, 0);
    cyc(4);
    chk("mismatch fault", mf, 1);
    chk("irq mismatch", irq, 1);
    rreg(8'h28);
    chk("mismatch status", d[4], 1);
    wreg(8'h1C, 32'h5);
    cyc(4);
    chk("as warning", {mf, mw}, 1);
    setc(16'h0F3D, 16'h0F3D, 16'h0F3D);
    cyc(4);
    chk("agree", {mf, mw}, 0);
    // only ch2 differs: seen in triple mode alone
    for (k = 0; k < 3; k = k + 1)
    begin
      wreg(8'h1C, k);
      setc(16'h0F3D, 16'h0F3D, 16'h1195);
      cyc(12);
      chk("mode", {mf, mw}, (k == 2) ? 2 : 0);
      setc(16'h0F3D, 16'h0F3D, 16'h0F3D);
      cyc(3);
    end
    wreg(8'h1C, 32'h1A);
    setc(16'h0F3D, 16'h0F3D, 16'h1195);
    cyc(12);
    chk("fail-safe", fs, 1);
    chk("fault withheld", mf, 0);
    chk("excess withheld", exf, 0);
    // second reset clears the latches; then a warning alone must reach fail-safe
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    cyc(3);
    chk("reset fail-safe", fs, 0);
    chk("reset excess", exf, 0);
    wreg(8'h18, 32'h5);
    wreg(8'h1C, 32'h26);
    cyc(12);
    chk("warning fail-safe", fs, 1);
    chk("warning withheld", {mf, mw}, 0);
    summarize;
  end
endmodule
